/* common/aslp_pkg.sv */
/*
 * constants shared by the sample lane packer: sample and lane geometry,
 * format select codes, octets per lane frame and lane counts per variant.
 * assumes a 10 MHz ref_clk and samples already aligned to the frame.
 */
package aslp_pkg;

    // geometry
    localparam int SAMP_W = 9;
    localparam int CH_MAX = 4;
    localparam int SPF = 4;
    localparam int LANE_MAX = 8;
    localparam int LANE_W = 40;
    localparam int FMT_W = 4;

    // format select codes
    localparam logic [3:0] FMT_1 = 4'h1;
    localparam logic [3:0] FMT_2 = 4'h2;
    localparam logic [3:0] FMT_3 = 4'h3;
    localparam logic [3:0] FMT_4 = 4'h4;
    localparam logic [3:0] FMT_5 = 4'h5;
    localparam logic [3:0] FMT_6 = 4'h6;
    localparam logic [3:0] FMT_7 = 4'h7;
    localparam logic [3:0] FMT_8 = 4'h8;
    localparam logic [3:0] FMT_9 = 4'h9;

    // octets per lane frame
    localparam logic [2:0] OCT_ONE = 3'h1;
    localparam logic [2:0] OCT_TWO = 3'h2;
    localparam logic [2:0] OCT_THREE = 3'h3;
    localparam logic [2:0] OCT_FIVE = 3'h5;

    // lane counts, index 0 quad, 1 dual, 2 single
    localparam logic [3:0] LN_SPLIT [0:2] = '{4'h6, 4'h3, 4'h2};
    localparam logic [3:0] LN_PERCH [0:2] = '{4'h4, 4'h2, 4'h1};
    localparam logic [3:0] LN_WIDE [0:2] = '{4'h3, 4'h2, 4'h1};
    localparam logic [3:0] LN_PAIR [0:2] = '{4'h2, 4'h1, 4'h1};
    localparam logic [3:0] LN_TWOPER [0:2] = '{4'h8, 4'h4, 4'h2};

endpackage

/* src/aslp_packer.sv */
/*
 * transport packer: maps 8/9-bit samples of up to four channels onto
 * lane octets for link formats 1 to 9. one frame of samples in, one
 * registered set of lane frames out a cycle later.
 * assumes samples, strobes and config come from logic on ref_clk and
 * that the receiver is configured the same before link_enable rises.
 */
`timescale 1ns/100ps

module aslp_packer #(
    parameter int NUM_CHANNELS = 4 // device variant: 1, 2 or 4
) (
    input wire logic ref_clk, // 10 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic [3:0] link_format_select, // format code 1..9
    input wire logic link_enable, // bring link up
    input wire logic frame_in_valid, // one frame of samples present
    input wire logic [35:0] samp_a, // channel a, sample k at [9k+8:9k]
    input wire logic [35:0] samp_b, // channel b
    input wire logic [35:0] samp_c, // channel c
    input wire logic [35:0] samp_d, // channel d
    output logic [319:0] lane_data, // lane i at [40i+39:40i], octet 0 high
    output logic [7:0] lane_enable, // active lanes
    output logic [2:0] lane_octets, // octets per lane frame
    output logic enc_64b66b, // 1: 64b/66b, 0: 8b/10b
    output logic frame_out_valid, // one-cycle pulse per packed frame
    output logic link_up, // running with a legal format
    output logic cfg_error // enabled with an illegal format
);

    typedef enum logic {ST_IDLE, ST_RUN} aslp_state_t;

    localparam int VAR = (NUM_CHANNELS == 4) ? 0 :
                         (NUM_CHANNELS == 2) ? 1 : 2;

    aslp_state_t state_reg;
    logic [3:0] fmt_reg;
    logic [319:0] lane_data_reg;
    logic [7:0] lane_enable_reg;
    logic [2:0] lane_octets_reg;
    logic enc_reg;
    logic fov_reg;
    logic cfg_error_reg;
    logic [35:0] raw [aslp_pkg::CH_MAX];
    logic [8:0] smp [aslp_pkg::CH_MAX][aslp_pkg::SPF];
    logic [15:0] pr_l [2][3];
    logic [15:0] w4_l [3];
    logic [39:0] ln [aslp_pkg::LANE_MAX];
    logic [319:0] lane_data_next;
    logic [7:0] lane_enable_next;
    logic [3:0] lane_cnt;
    logic [2:0] lane_octets_next;
    logic enc_next;
    logic fmt_legal;

    assign raw[0] = samp_a;
    assign raw[1] = samp_b;
    assign raw[2] = samp_c;
    assign raw[3] = samp_d;

    // channels the variant lacks read as zero samples
    genvar gc;
    genvar gs;
    generate
        for (gc = 0; gc < aslp_pkg::CH_MAX; gc++)
        begin : g_ch
            for (gs = 0; gs < aslp_pkg::SPF; gs++)
            begin : g_s
                assign smp[gc][gs] = (gc < NUM_CHANNELS) ?
                    raw[gc][9*gs +: 9] : 9'h000;
            end
        end
    endgenerate

    // split layout for channel pairs a/b and c/d, formats 1 and 6
    generate
        for (gc = 0; gc < 2; gc++)
        begin : g_pair
            aslp_split9 u_pair (
                .x0(smp[2*gc][0]),
                .x1(smp[2*gc][1]),
                .y0(smp[2*gc+1][0]),
                .y1(smp[2*gc+1][1]),
                .y_keep(NUM_CHANNELS > 2*gc+1),
                .lane0(pr_l[gc][0]),
                .lane1(pr_l[gc][1]),
                .lane2(pr_l[gc][2])
            );
        end
    endgenerate

    // format 4 spreads one sample of each channel over three lanes
    aslp_split9 u_wide (
        .x0(smp[0][0]),
        .x1(smp[1][0]),
        .y0(smp[2][0]),
        .y1(smp[3][0]),
        .y_keep(NUM_CHANNELS > 1),
        .lane0(w4_l[0]),
        .lane1(w4_l[1]),
        .lane2(w4_l[2])
    );

    assign fmt_legal = (fmt_reg >= aslp_pkg::FMT_1) &&
                       (fmt_reg <= aslp_pkg::FMT_9);

    // lane frames, lane count, octet count and encoding per format
    always_comb
    begin
        for (int i = 0; i < aslp_pkg::LANE_MAX; i++)
            ln[i] = 40'h00_0000_0000;
        lane_cnt = 4'h0;
        lane_octets_next = aslp_pkg::OCT_ONE;
        enc_next = 1'b0;
        unique case (fmt_reg)
            aslp_pkg::FMT_1, aslp_pkg::FMT_6:
            begin
                for (int p = 0; p < 2; p++)
                    for (int k = 0; k < 3; k++)
                        ln[3*p+k] = {pr_l[p][k], 24'h00_0000};
                lane_cnt = aslp_pkg::LN_SPLIT[VAR];
                lane_octets_next = aslp_pkg::OCT_TWO;
                enc_next = (fmt_reg == aslp_pkg::FMT_6);
            end
            aslp_pkg::FMT_2, aslp_pkg::FMT_7:
            begin
                for (int c = 0; c < aslp_pkg::CH_MAX; c++)
                    ln[c] = {smp[c][0][8:1], 32'h0000_0000};
                lane_cnt = aslp_pkg::LN_PERCH[VAR];
                enc_next = (fmt_reg == aslp_pkg::FMT_7);
            end
            aslp_pkg::FMT_3:
            begin
                for (int c = 0; c < aslp_pkg::CH_MAX; c++)
                    ln[c] = {smp[c][0], 1'b0, smp[c][1], 1'b0,
                             smp[c][2], 1'b0, smp[c][3], 1'b0};
                lane_cnt = aslp_pkg::LN_PERCH[VAR];
                lane_octets_next = aslp_pkg::OCT_FIVE;
            end
            aslp_pkg::FMT_4:
            begin
                for (int k = 0; k < 3; k++)
                    ln[k] = {w4_l[k], 24'h00_0000};
                lane_cnt = aslp_pkg::LN_WIDE[VAR];
                lane_octets_next = aslp_pkg::OCT_TWO;
                enc_next = 1'b1;
            end
            aslp_pkg::FMT_5:
            begin
                // absent second channel is already a zero sample
                ln[0] = {smp[0][0][8:1], smp[1][0][8:1],
                         24'h00_0000};
                ln[1] = {smp[2][0][8:1], smp[3][0][8:1], 24'h00_0000};
                lane_cnt = aslp_pkg::LN_PAIR[VAR];
                lane_octets_next = aslp_pkg::OCT_TWO;
                enc_next = 1'b1;
            end
            aslp_pkg::FMT_8:
            begin
                for (int c = 0; c < aslp_pkg::CH_MAX; c++)
                    ln[c] = {smp[c][0], 3'h0, smp[c][1], 3'h0,
                             16'h0000};
                lane_cnt = aslp_pkg::LN_PERCH[VAR];
                lane_octets_next = aslp_pkg::OCT_THREE;
                enc_next = 1'b1;
            end
            aslp_pkg::FMT_9:
            begin
                for (int c = 0; c < aslp_pkg::CH_MAX; c++)
                begin
                    ln[2*c] = {smp[c][0][8:1], 32'h0000_0000};
                    ln[2*c+1] = {smp[c][1][8:1], 32'h0000_0000};
                end
                lane_cnt = aslp_pkg::LN_TWOPER[VAR];
            end
            default:
            begin
                lane_cnt = 4'h0; // illegal code: no lanes
            end
        endcase
    end

    // lanes past the variant's count stay idle and carry zeros
    always_comb
    begin
        for (int i = 0; i < aslp_pkg::LANE_MAX; i++)
        begin
            lane_enable_next[i] = (4'(i) < lane_cnt);
            lane_data_next[40*i +: 40] =
                lane_enable_next[i] ? ln[i] : 40'h00_0000_0000;
        end
    end

    // format is only taken while the link is down, so the receiver
    // never sees the layout change under a running link
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            fmt_reg <= 4'h0;
            cfg_error_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    cfg_error_reg <= link_enable && !fmt_legal;
                    // keep the checked code on the edge that starts the
                    // link, so an unchecked code never goes live
                    if (link_enable && fmt_legal)
                        state_reg <= ST_RUN;
                    else
                        fmt_reg <= link_format_select;
                end
                ST_RUN:
                begin
                    cfg_error_reg <= 1'b0;
                    if (!link_enable)
                        state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // lane configuration loaded on running cycles, so it trails link_up by one cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            lane_enable_reg <= 8'h00;
            lane_octets_reg <= 3'h0;
            enc_reg <= 1'b0;
        end
        else if (state_reg == ST_RUN)
        begin
            lane_enable_reg <= lane_enable_next;
            lane_octets_reg <= lane_octets_next;
            enc_reg <= enc_next;
        end
        else
        begin
            lane_enable_reg <= 8'h00;
            lane_octets_reg <= 3'h0;
            enc_reg <= 1'b0;
        end
    end

    // one packed frame per accepted sample frame; data holds between
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            lane_data_reg <= '0;
            fov_reg <= 1'b0;
        end
        else
        begin
            fov_reg <= frame_in_valid && (state_reg == ST_RUN);
            if (frame_in_valid && (state_reg == ST_RUN))
                lane_data_reg <= lane_data_next;
        end
    end

    assign lane_data = lane_data_reg;
    assign lane_enable = lane_enable_reg;
    assign lane_octets = lane_octets_reg;
    assign enc_64b66b = enc_reg;
    assign frame_out_valid = fov_reg;
    assign link_up = (state_reg == ST_RUN);
    assign cfg_error = cfg_error_reg;

endmodule

/* src/aslp_split9.sv */
/*
 * two-octet split layout for four 9-bit samples over three lanes.
 * x0,x1 fill lane 0 and the head of lane 1; y0,y1 the rest.
 * purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps

module aslp_split9 (
    input wire logic [8:0] x0, // first sample, first lane
    input wire logic [8:0] x1, // second sample, split lanes 0/1
    input wire logic [8:0] y0, // third sample, split lanes 1/2
    input wire logic [8:0] y1, // fourth sample, lane 2
    input wire logic y_keep, // low when the y channel is absent
    output logic [15:0] lane0, // first lane frame
    output logic [15:0] lane1, // second lane frame
    output logic [15:0] lane2 // third lane frame
);

    logic [8:0] y0_k;
    logic [8:0] y1_k;

    // absent partner fills its octets with zeros
    assign y0_k = y_keep ? y0 : 9'h000;
    assign y1_k = y_keep ? y1 : 9'h000;

    // sample bits straddle lane boundaries, three zero pad bits each
    assign lane0 = {x0, 3'h0, x1[8:5]};
    assign lane1 = {x1[4:0], 3'h0, y0_k[8:1]};
    assign lane2 = {y0_k[0], 3'h0, y1_k, 3'h0};

endmodule

/* testbench/aslp_packer_chk.sv */
/*
 * checker for the sample lane packer: frame timing and lane layout
 * relations seen on the top module's ports only.
 * assumes one clock, ref_clk, and rst as async active high reset.
 */
`timescale 1ns/100ps

module aslp_packer_chk #(
    parameter int NUM_CHANNELS = 4 // device variant
) (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic link_enable, // link request
    input wire logic frame_in_valid, // frame strobe in
    input wire logic [319:0] lane_data, // lane frames
    input wire logic [7:0] lane_enable, // active lanes
    input wire logic [2:0] lane_octets, // octets per lane
    input wire logic enc_64b66b, // encoding select
    input wire logic frame_out_valid, // frame strobe out
    input wire logic link_up, // running
    input wire logic cfg_error // illegal format seen
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // a frame counts only while the link runs
    sequence frame_taken;
        frame_in_valid && link_up;
    endsequence

    frame_pulse_a: assert property (frame_taken |=> frame_out_valid)
        else $error("packed frame missing after capture");
    no_spurious_a: assert property (!(frame_in_valid && link_up)
        |=> !frame_out_valid) else $error("frame out without capture");
    data_hold_a: assert property (!frame_out_valid
        |-> $stable(lane_data))
        else $error("lane data moved without a frame");
    link_cause_a: assert property (link_up |-> $past(link_enable))
        else $error("link up without enable");
    cfg_idle_a: assert property (cfg_error |-> !link_up)
        else $error("running with a config error");
    five_oct_a: assert property (lane_octets == 3'h5 |-> !enc_64b66b)
        else $error("five octet frames on wrong encoding");
    split_lanes_a: assert property (lane_enable == 8'h3F
        |-> lane_octets == 3'h2) else $error("six lanes not two octets");
    three_oct_a: assert property (lane_octets == 3'h3 |-> enc_64b66b)
        else $error("three octet frames on wrong encoding");
    eight_lanes_a: assert property (lane_enable == 8'hFF
        |-> lane_octets == 3'h1 && !enc_64b66b)
        else $error("eight lanes with wrong frame shape");
    variant_lanes_a: assert property ((NUM_CHANNELS < 4)
        |-> lane_enable[7:4] == 4'h0) else $error("upper lanes on small part");
    single_zero_a: assert property ((NUM_CHANNELS == 1
        && lane_octets == 3'h2) |-> lane_data[71:64] == 8'h00)
        else $error("absent channel octet not zero");
endmodule

bind aslp_packer aslp_packer_chk #(.NUM_CHANNELS(NUM_CHANNELS)) chk_u (
    .ref_clk(ref_clk), .rst(rst), .link_enable(link_enable),
    .frame_in_valid(frame_in_valid), .lane_data(lane_data),
    .lane_enable(lane_enable), .lane_octets(lane_octets),
    .enc_64b66b(enc_64b66b), .frame_out_valid(frame_out_valid),
    .link_up(link_up), .cfg_error(cfg_error));

/* testbench/aslp_rx_model.sv */
/*
 * receiver side model: masks each frame with the current lane set and keeps the
 * last packed frame, dropping lanes it was not told to use.
 * assumes it sits on ref_clk beside the packer outputs.
 */
`timescale 1ns/100ps

module aslp_rx_model (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic [319:0] lane_data, // lane frames
    input wire logic [7:0] lane_enable, // active lanes
    input wire logic frame_out_valid, // frame strobe
    output logic [319:0] rx_frame // last frame received
);
    logic [319:0] lane_mask;

    // lane set follows lane_enable every cycle; both ends agree up front
    always_comb
        for (int i = 0; i < 8; i++)
            lane_mask[40*i +: 40] = {40{lane_enable[i]}};

    // frames land only on lanes that are in use
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rx_frame <= '0;
        else if (frame_out_valid)
            rx_frame <= lane_data & lane_mask;
    end
endmodule

/* testbench/tb_aslp_packer.sv */
/*
 * testbench: quad and single packers fed the same frames; one row per
 * format, then refusal, back-to-back and idle cases.
 * assumes the 10 MHz clock and one-cycle latencies of the packer.
 */
`timescale 1ns/100ps

module tb_aslp_packer;
    typedef struct packed {
        logic [3:0] f;
        logic [7:0] m;
        logic [2:0] o;
        logic e;
        logic [79:0] q;
        logic [79:0] s;
    } aslp_row_t;
    // {lane1, lane0} expected for quad (q) and single (s)
    aslp_row_t rows [9] = '{
        '{4'h1, 8'h3F, 3'h2, 1'b0, 80'h5087000000AA85000000,
            80'h5000000000AA85000000},
        '{4'h2, 8'h0F, 3'h1, 1'b0, 80'h8700000000AA00000000,
            80'hAA00000000},
        '{4'h3, 8'h0F, 3'h5, 1'b0, 80'h879E000000AA954FF806,
            80'hAA954FF806},
        '{4'h4, 8'h07, 3'h2, 1'b1, 80'h7899000000AA88000000,
            80'hAA80000000},
        '{4'h5, 8'h03, 3'h2, 1'b1, 80'h99F0000000AA87000000,
            80'hAA00000000},
        '{4'h6, 8'h3F, 3'h2, 1'b1, 80'h5087000000AA85000000,
            80'h5000000000AA85000000},
        '{4'h7, 8'h0F, 3'h1, 1'b1, 80'h8700000000AA00000000,
            80'hAA00000000},
        '{4'h8, 8'h0F, 3'h3, 1'b1, 80'h8787800000AA85500000,
            80'hAA85500000},
        '{4'h9, 8'hFF, 3'h1, 1'b0, 80'h5500000000AA00000000,
            80'h5500000000AA00000000}};
    logic ref_clk, rst, link_enable, frame_in_valid;
    logic [3:0] link_format_select;
    logic [35:0] samp_a, samp_b, samp_c, samp_d;
    logic [319:0] lane_data, s_lane_data, rx_frame;
    logic [7:0] lane_enable;
    logic [2:0] lane_octets;
    logic enc_64b66b, frame_out_valid, link_up, cfg_error;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;

    aslp_packer #(.NUM_CHANNELS(4)) dut_u (.ref_clk(ref_clk), .rst(rst),
        .link_format_select(link_format_select), .link_enable(link_enable),
        .frame_in_valid(frame_in_valid), .samp_a(samp_a), .samp_b(samp_b),
        .samp_c(samp_c), .samp_d(samp_d), .lane_data(lane_data),
        .lane_enable(lane_enable), .lane_octets(lane_octets),
        .enc_64b66b(enc_64b66b), .frame_out_valid(frame_out_valid),
        .link_up(link_up), .cfg_error(cfg_error));
    // single channel part sees the same stimulus
    aslp_packer #(.NUM_CHANNELS(1)) dut_s (.ref_clk(ref_clk), .rst(rst),
        .link_format_select(link_format_select), .link_enable(link_enable),
        .frame_in_valid(frame_in_valid), .samp_a(samp_a), .samp_b(samp_b),
        .samp_c(samp_c), .samp_d(samp_d), .lane_data(s_lane_data),
        .lane_enable(), .lane_octets(), .enc_64b66b(), .frame_out_valid(),
        .link_up(), .cfg_error());
    aslp_rx_model rx_u (.ref_clk(ref_clk), .rst(rst), .lane_data(lane_data),
        .lane_enable(lane_enable), .frame_out_valid(frame_out_valid),
        .rx_frame(rx_frame));

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [79:0] e,
                       input logic [79:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask

    // format is set a cycle ahead of the enable, as the packer needs
    task automatic bring_up(input logic [3:0] f);
        @(posedge ref_clk);
        link_enable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        link_format_select <= f;
        @(posedge ref_clk);
        link_enable <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic send_frame();
        @(posedge ref_clk);
        frame_in_valid <= 1'b1;
        @(posedge ref_clk);
        frame_in_valid <= 1'b0;
        #1 chk("frame_out_valid", 80'h1, 80'(frame_out_valid));
        @(posedge ref_clk);
        #1 chk("frame_out_valid low", 80'h0, 80'(frame_out_valid));
    endtask

    // hang guard, well above the expected run
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            error_cnt++;
            final_report();
        end
    end

    initial
    begin
        rst = 1'b1;
        link_enable = 1'b0;
        frame_in_valid = 1'b0;
        link_format_select = 4'h0;
        samp_a = {9'h003, 9'h1FF, 9'h0AA, 9'h155};
        samp_b = {18'h0, 9'h0F0, 9'h10F};
        samp_c = {18'h0, 9'h0CC, 9'h133};
        samp_d = {18'h0, 9'h01E, 9'h1E1};
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk("reset", 80'h0, 80'({link_up, cfg_error, lane_enable}));
        foreach (rows[i])
        begin
            bring_up(rows[i].f);
            chk("lane_enable", 80'(rows[i].m), 80'(lane_enable));
            chk("octets", 80'(rows[i].o), 80'(lane_octets));
            chk("encoding", 80'(rows[i].e), 80'(enc_64b66b));
            send_frame();
            chk("quad lanes", rows[i].q, rx_frame[79:0]);
            chk("single lanes", rows[i].s, s_lane_data[79:0]);
            $display("format %0d done", rows[i].f);
        end
        // format change while running is ignored
        bring_up(4'h5);
        @(posedge ref_clk);
        link_format_select <= 4'h2;
        repeat (2) @(posedge ref_clk);
        send_frame();
        chk("held format", rows[4].q, rx_frame[79:0]);
        chk("single zero", rows[4].s, s_lane_data[79:0]);
        chk("held octets", 80'h2, 80'(lane_octets));
        // back-to-back frames give back-to-back strobes
        @(posedge ref_clk);
        frame_in_valid <= 1'b1;
        @(posedge ref_clk);
        #1 chk("first of pair", 80'h1, 80'(frame_out_valid));
        @(posedge ref_clk);
        frame_in_valid <= 1'b0;
        #1 chk("second of pair", 80'h1, 80'(frame_out_valid));
        $display("running cases done");
        // idle frames are dropped
        @(posedge ref_clk);
        link_enable <= 1'b0;
        repeat (3) @(posedge ref_clk);
        frame_in_valid <= 1'b1;
        @(posedge ref_clk);
        frame_in_valid <= 1'b0;
        #1 chk("idle frame", 80'h0, 80'({link_up, frame_out_valid}));
        // an illegal code keeps the link down
        bring_up(4'h0);
        chk("illegal code", 80'h1, 80'({link_up, cfg_error}));
        $display("idle cases done");
        // lanes past the first two on the quad part
        bring_up(4'h9);
        send_frame();
        chk("f9 lanes 3/2", 80'h78000000008700000000, rx_frame[159:80]);
        chk("f9 lanes 5/4", 80'h66000000009900000000, rx_frame[239:160]);
        chk("f9 lanes 7/6", 80'h0F00000000F000000000, rx_frame[319:240]);
        bring_up(4'h1);
        send_frame();
        chk("f1 lanes 3/2", 80'h99860000008780000000, rx_frame[159:80]);
        chk("f1 lanes 5/4", 80'h80F000000060F0000000, rx_frame[239:160]);
        chk("f1 lanes 7/6", 80'h0, lane_data[319:240]);
        $display("upper lane cases done");
        // reset in mid-run clears every output, frame data included
        @(posedge ref_clk);
        rst <= 1'b1;
        link_enable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk("mid reset", 80'h0, 80'({link_up, cfg_error, lane_enable}));
        chk("mid cfg", 80'h0, 80'({enc_64b66b, lane_octets}));
        chk("mid data", 80'h0, lane_data[79:0]);
        $display("reset case done");
        final_report();
    end
endmodule
